/* design/serial_link_port.sv */
`timescale 1ns/1ps
`include "range_defines.svh"

module serial_link_port (
	input wire logic i_sclk, // Serial clock from the host.
	input wire logic i_link_rst, // Active-high reset, asserted async.
	input wire logic i_cs_n, // Frame select, active low.
	input wire logic i_sdi, // Serial data in, sampled on rising edge.
	input wire logic i_pub_tgl, // Toggles when the bundle below is new.
	input wire logic [7:0] i_last_cmd, // Upper byte of the executed command.
	input wire range_pkg::span_array_t i_span, // Current range selects.
	output logic o_cmd_tgl, // Toggles when o_cmd holds a new word.
	output logic [15:0] o_cmd, // Last complete command word.
	output logic o_sdo // Serial data out, driven on falling edge.
);
	import range_pkg::*;

	link_state_t q;
	link_state_t d;
	logic [5:0] bit_cnt_q;
	logic [5:0] bit_cnt_d;
	logic [5:0] out_pos;
	logic sdo_q;
	logic [15:0] word;
	prog_addr_t addr;
	logic frame_rst;

	// Device reset also clears the frame counter, so the first frame after
	// power-up never starts from an unknown count.
	assign frame_rst = i_cs_n | i_link_rst;
	assign o_cmd_tgl = q.cmd_tgl;
	assign o_cmd = q.cmd;
	assign o_sdo = sdo_q;
	assign out_pos = `FRAME_LAST_EDGE - bit_cnt_q;

	////////////////////////////////////////////////////////////////////////
	// The edge counter restarts with every frame; it saturates so that a
	// long frame never wraps into a second reply.
	assign bit_cnt_d = (bit_cnt_q == `FRAME_END_COUNT) ? bit_cnt_q :
		bit_cnt_q + 6'h01;

	always_ff @(posedge i_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_q <= '0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		word = {q.shift[14:0], i_sdi};
		addr = word[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
		// The clock only runs in frames, so the bundle is picked up within
		// the first three edges, long before the reply is built.
		d.pub_s1 = i_pub_tgl;
		d.pub_s2 = q.pub_s1;
		d.pub_seen = q.pub_s2;
		if (q.pub_s2 != q.pub_seen) begin
			d.last_cmd = i_last_cmd;
			d.span = i_span;
		end
		if (bit_cnt_q < `CMD_BITS) begin
			d.shift = word;
		end
		if (bit_cnt_q == `LAST_CMD_EDGE) begin
			d.cmd = word;
			d.cmd_tgl = ~q.cmd_tgl;
			d.resp = `REPLY_NONE;
			if (!word[`CMD_WRITE_BIT] && addr == `READBACK_ADDR) begin
				d.resp = {q.last_cmd, `REPLY_PAD_ZERO};
			end else if (!word[`CMD_WRITE_BIT] && is_range_addr(addr)) begin
				d.resp = {`RANGE_PAD_ZERO, q.span[range_index(addr)],
					`REPLY_PAD_ZERO};
			end
		end
	end

	always_ff @(posedge i_sclk or posedge i_link_rst) begin
		if (i_link_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reply leaves MSB first from the sixteenth falling edge on.
	always_ff @(negedge i_sclk or posedge frame_rst) begin
		if (frame_rst) begin
			sdo_q <= 1'b0;
		end else if (bit_cnt_q >= `CMD_BITS && bit_cnt_q < `FRAME_END_COUNT)
		begin
			sdo_q <= q.resp[out_pos[3:0]];
		end else begin
			sdo_q <= 1'b0;
		end
	end

endmodule // serial_link_port

/* include/range_defines.svh */
`ifndef RANGE_DEFINES_SVH
`define RANGE_DEFINES_SVH

// Frame and register layout constants.
`define NUM_CHANNELS 8
`define CMD_ADDR_MSB 15
`define CMD_ADDR_LSB 9
`define CMD_WRITE_BIT 8
`define CMD_UPPER_MSB 15
`define CMD_UPPER_LSB 8
`define SPAN_MSB 2
`define SPAN_LSB 0
`define RANGE_ADDR_FIRST 7'h05
`define RANGE_ADDR_LAST 7'h0c
`define READBACK_ADDR 7'h3f
`define SPAN_RESET 3'h0
`define READBACK_RESET 8'h00
`define RANGE_PAD_ZERO 5'h00
`define REPLY_PAD_ZERO 8'h00
`define REPLY_NONE 16'h0000
`define CMD_BITS 6'h10
`define LAST_CMD_EDGE 6'h0f
`define FRAME_LAST_EDGE 6'h1f
`define FRAME_END_COUNT 6'h20

`endif

/* include/range_pkg.sv */
package range_pkg;
`include "range_defines.svh"

	typedef logic [2:0] span_t;
	typedef span_t [`NUM_CHANNELS-1:0] span_array_t;
	typedef logic [6:0] prog_addr_t;

	typedef struct packed {
		logic link_rst;
		logic cmd_s1;
		logic cmd_s2;
		logic cmd_seen;
		logic pub_tgl;
		logic [7:0] last_cmd;
		span_array_t span;
	} sys_state_t;

	typedef struct packed {
		logic [15:0] shift;
		logic [15:0] cmd;
		logic cmd_tgl;
		logic pub_s1;
		logic pub_s2;
		logic pub_seen;
		logic [7:0] last_cmd;
		span_array_t span;
		logic [15:0] resp;
	} link_state_t;

	function automatic logic is_range_addr(input prog_addr_t a);
		return (a >= `RANGE_ADDR_FIRST) && (a <= `RANGE_ADDR_LAST);
	endfunction

	function automatic logic [2:0] range_index(input prog_addr_t a);
		prog_addr_t diff;
		diff = a - `RANGE_ADDR_FIRST;
		return diff[2:0];
	endfunction

endpackage

/* design/range_select_and_cmd_readback.sv */
// Contract
// - Range register bits 7:3 read zero, are not stored, reset zero.
// - Each channel has a writable 3-bit span select code.
// - All span selects reset to zero, the widest bipolar span.
// - Read command at program address 3Fh returns the readback register.
// - Readback returns the command executed in the previous frame.
// - Returned word leaves MSB first from the sixteenth falling edge.
// - Eight command bits are followed by eight zero bits.
// - Readback register holds upper command byte, read only, resets zero.
`timescale 1ns/1ps
`include "range_defines.svh"

module range_select_and_cmd_readback (
	input wire logic i_clk, // System clock, 125 MHz.
	input wire logic i_reset_n, // Synchronous reset, active low.
	input wire logic i_sclk, // Serial clock from the host.
	input wire logic i_cs_n, // Frame select, active low.
	input wire logic i_sdi, // Serial data in.
	output logic o_sdo, // Serial data out.
	output range_pkg::span_array_t o_channel_span_select, // Range codes.
	output logic [7:0] o_command_readback // Upper byte of last command.
);
	import range_pkg::*;

	sys_state_t q;
	sys_state_t d;
	logic link_cmd_tgl;
	logic [15:0] link_cmd;
	prog_addr_t cmd_addr;

	localparam sys_state_t SYS_RESET = '{
		link_rst: 1'b1,
		cmd_s1: 1'b0,
		cmd_s2: 1'b0,
		cmd_seen: 1'b0,
		pub_tgl: 1'b0,
		last_cmd: `READBACK_RESET,
		span: {`NUM_CHANNELS{`SPAN_RESET}}
	};

	assign o_channel_span_select = q.span;
	assign o_command_readback = q.last_cmd;
	assign cmd_addr = link_cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB];

	////////////////////////////////////////////////////////////////////////
	// The serial side shifts and replies on the host clock; it only hands
	// complete words over, so nothing is shared bit by bit.
	serial_link_port u_link (
		.i_sclk(i_sclk),
		.i_link_rst(q.link_rst),
		.i_cs_n(i_cs_n),
		.i_sdi(i_sdi),
		.i_pub_tgl(q.pub_tgl),
		.i_last_cmd(q.last_cmd),
		.i_span(q.span),
		.o_cmd_tgl(link_cmd_tgl),
		.o_cmd(link_cmd),
		.o_sdo(o_sdo)
	);

	////////////////////////////////////////////////////////////////////////
	// The command word is held still by the link until the next frame's
	// sixteenth edge, so it is safe to read once the toggle is seen.
	always_comb begin
		d = q;
		d.link_rst = 1'b0;
		d.cmd_s1 = link_cmd_tgl;
		d.cmd_s2 = q.cmd_s1;
		d.cmd_seen = q.cmd_s2;
		if (q.cmd_s2 != q.cmd_seen) begin
			d.last_cmd = link_cmd[`CMD_UPPER_MSB:`CMD_UPPER_LSB];
			if (link_cmd[`CMD_WRITE_BIT] && is_range_addr(cmd_addr)) begin
				// Upper data bits are dropped so they always read zero.
				d.span[range_index(cmd_addr)] =
					link_cmd[`SPAN_MSB:`SPAN_LSB];
			end
			d.pub_tgl = ~q.pub_tgl;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			q <= SYS_RESET;
		end else begin
			q <= d;
		end
	end

endmodule // range_select_and_cmd_readback

/* test/range_chk.sv */
`timescale 1ns/1ps
module range_chk (
	input wire logic i_clk, // Clock.
	input wire logic i_reset_n, // Reset.
	input wire logic i_sclk, // Serial clock.
	input wire logic i_cs_n, // Select.
	input wire logic i_sdi, // Serial in.
	input wire logic o_sdo, // Serial out.
	input wire range_pkg::span_array_t o_channel_span_select, // Spans.
	input wire logic [7:0] o_command_readback // Readback.
);
	import range_pkg::*;
	logic [5:0] n_q;
	// Falling edges so far in this frame; a high select clears it.
	always_ff @(negedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n)
			n_q <= 6'h00;
		else
			n_q <= n_q + 6'h01;
	end
	sequence s_quiet; i_cs_n [*8]; endsequence
	property p_r3;
		@(posedge i_clk) !i_reset_n |=> o_channel_span_select == '0;
	endproperty
	property p_r9;
		@(posedge i_clk) !i_reset_n |=> o_command_readback == 8'h00;
	endproperty
	property p_hs; @(posedge i_clk) disable iff (!i_reset_n)
		s_quiet |=> $stable(o_channel_span_select); endproperty
	property p_hr; @(posedge i_clk) disable iff (!i_reset_n)
		s_quiet |=> $stable(o_command_readback); endproperty
	property p_idle; @(posedge i_clk) disable iff (!i_reset_n)
		i_cs_n |-> !o_sdo; endproperty
	property p_fall; @(posedge i_clk) disable iff (!i_reset_n)
		$changed(o_sdo) |-> !i_sclk || i_cs_n; endproperty
	property p_pre; @(posedge i_sclk) disable iff (i_cs_n)
		n_q < 6'h10 |-> !o_sdo; endproperty
	property p_tail; @(posedge i_sclk) disable iff (i_cs_n)
		n_q >= 6'h18 |-> !o_sdo; endproperty
	a_r3: assert property (p_r3) else $error("span reset");
	a_r9: assert property (p_r9) else $error("rb reset");
	a_hs: assert property (p_hs) else $error("span moved");
	a_hr: assert property (p_hr) else $error("rb moved");
	a_idle: assert property (p_idle) else $error("sdo idle");
	a_fall: assert property (p_fall) else $error("sdo edge");
	a_pre: assert property (p_pre) else $error("sdo early");
	a_tail: assert property (p_tail) else $error("sdo tail");
endmodule // range_chk

/* test/host_model.sv */
`timescale 1ns/1ps
module host_model (
	output logic o_sclk, // Serial clock.
	output logic o_cs_n, // Select.
	output logic o_sdi, // Data out.
	input wire logic i_sdo // Data in.
);
	logic [31:0] rx;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_sdi = 1'b0;
		// A real rising select edge clears every frame counter at start.
		#2 o_cs_n = 1'b1;
	end
	// Clock stands low between frames; a frame may stop after 24.
	task automatic xfer(input logic [15:0] w, input int len);
		rx = '0;
		// The offset keeps the first serial edges off the system clock edges; the 1 ns sample steps later put some on them.
		#3 o_cs_n = 1'b0;
		for (int i = 0; i < len; i++) begin
			o_sdi = (i < 16) ? w[15 - i] : ~o_sdi;
			#80 o_sclk = 1'b1;
			#80 o_sclk = 1'b0;
			#1 rx = {rx[30:0], i_sdo};
		end
		#40 o_cs_n = 1'b1;
		o_sdi = ~o_sdi;
	endtask
endmodule // host_model

/* test/range_select_and_cmd_readback_tb.sv */
`timescale 1ns/1ps
module range_select_and_cmd_readback_tb;
	import range_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic sclk, cs_n, sdi, sdo;
	span_array_t span, sp;
	logic [7:0] rb;
	logic [15:0] prev, w, r;
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int len;
	always #4 i_clk = ~i_clk;
	range_select_and_cmd_readback DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo),
		.o_channel_span_select(span), .o_command_readback(rb));
	host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
	task automatic chk_reply(input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value reply expected %h seen %h", e, g);
		end
	endtask
	task automatic chk_span(input span_array_t e, input span_array_t g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value span expected %h seen %h", e, g);
		end
	endtask
	task automatic chk_rb(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value readback expected %h seen %h", e, g);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] exp_rep(logic [15:0] c);
		if (c[8])
			return 16'h0000;
		if (c[15:9] == 7'h3f)
			return {prev[15:8], 8'h00};
		if (c[15:9] >= 7'h05 && c[15:9] <= 7'h0c)
			return {5'h00, sp[c[11:9] - 3'h5], 8'h00};
		return 16'h0000;
	endfunction
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		void'($urandom(65064));
		sp = '0;
		prev = 16'h0000;
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk_span(sp, span);
		chk_rb(8'h00, rb);
		for (int k = 0; k < 60; k++) begin
			if (k == 30) begin
				// Mid-run reset while the select stands high.
				i_reset_n <= 1'b0;
				repeat (4) @(posedge i_clk);
				i_reset_n <= 1'b1;
				repeat (3) @(posedge i_clk);
				sp = '0;
				prev = 16'h0000;
				chk_span(sp, span);
				chk_rb(8'h00, rb);
			end
			// The host keeps data bits 7:3 at zero on every write.
			w = {7'($urandom % 16), 1'($urandom), 5'h00, 3'($urandom)};
			if (k % 3 == 0)
				w = 16'h7e00;
			len = (k % 2) ? 24 : 32;
			host.xfer(w, len);
			r = (len == 32) ? host.rx[16:1] : {host.rx[8:1], 8'h00};
			chk_reply(exp_rep(w), r);
			if (w[8] && w[15:9] >= 7'h05 && w[15:9] <= 7'h0c)
				sp[w[11:9] - 3'h5] = w[2:0];
			prev = w;
			repeat (8 + $urandom % 8) @(posedge i_clk);
			chk_span(sp, span);
			chk_rb(w[15:8], rb);
		end
		summarize();
	end
endmodule // range_select_and_cmd_readback_tb
bind range_select_and_cmd_readback range_chk chk_i (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi),
	.o_sdo(o_sdo), .o_channel_span_select(o_channel_span_select),
	.o_command_readback(o_command_readback));
